// ===== common/blabs_pkg.sv
// constants and types of the front-panel address/baud sequencer
package blabs_pkg;
    // ---------------------------------------------------------
    // time base
    // ---------------------------------------------------------
    localparam int BLABS_CLK_HZ   = 100_000_000;
    localparam int BLABS_TICK_MS  = 100;
    localparam int BLABS_TICK_CYC = BLABS_CLK_HZ / 1000 * BLABS_TICK_MS;

    localparam int BLABS_FAST_MS  = 100;
    localparam int BLABS_HALF_MS  = 500;
    localparam int BLABS_GAP_MS   = 1000;
    localparam int BLABS_TOUT_MS  = 60000;

    localparam logic [3:0] BLABS_HALF_TK = 4'(BLABS_HALF_MS / BLABS_TICK_MS);
    localparam logic [3:0] BLABS_GAP_TK  = 4'(BLABS_GAP_MS / BLABS_TICK_MS);
    localparam logic [3:0] BLABS_FAST_TK = 4'(BLABS_FAST_MS / BLABS_TICK_MS);
    localparam logic [9:0] BLABS_TOUT_TK = 10'(BLABS_TOUT_MS / BLABS_TICK_MS);

    // ---------------------------------------------------------
    // counts and reset values
    // ---------------------------------------------------------
    localparam logic [2:0] BLABS_CFG_PRESSES  = 3'h5;
    localparam logic [2:0] BLABS_SHOW_PRESSES = 3'h3;
    localparam logic [3:0] BLABS_TENS_MAX     = 4'hC;
    localparam logic [3:0] BLABS_UNITS_MAX    = 4'h9;
    localparam logic [3:0] BLABS_BAUD_MAX     = 4'h5;
    localparam logic [3:0] BLABS_TENS_RST     = 4'h0;
    localparam logic [3:0] BLABS_UNITS_RST    = 4'h1;
    localparam logic [3:0] BLABS_BAUD_RST     = 4'h2;
    localparam logic [3:0] BLABS_TEN          = 4'hA;

    // ---------------------------------------------------------
    // types
    // ---------------------------------------------------------
    typedef enum logic [3:0] {
        BLABS_ST_RUN   = 4'h1,
        BLABS_ST_WAIT  = 4'h2,
        BLABS_ST_COUNT = 4'h4,
        BLABS_ST_SHOW  = 4'h8
    } blabs_state_e;

    typedef enum logic [2:0] {
        BLABS_PH_TENS  = 3'h1,
        BLABS_PH_UNITS = 3'h2,
        BLABS_PH_BAUD  = 3'h4
    } blabs_phase_e;

    typedef struct packed {
        logic green;
        logic red;
    } blabs_led_s;
endpackage : blabs_pkg

// ===== logic/blabs_top.sv
// front-panel switch/LED sequencer for bus address and baud code
`timescale 1ns/10ps

// Notes on behaviour
// - five short presses enter configuration
// - each phase must start within 60 s
// - waiting phase LEDs blink 0.1 s
// - press blanks LEDs, starts counting
// - flash 0.5/0.5 s, zero is 1 s dark
// - green counts tens, latched on release
// - tens count wraps after 12
// - red counts units, wraps after 9
// - both LEDs count baud code 1..5
// - baud code wraps after 5
// - baud code zero keeps old rate
// - apply only after all phases complete
// - return to running mode afterwards
// - three short presses show current settings
module blabs_top
    import blabs_pkg::*;
#(
    parameter int TICK_CYC = BLABS_TICK_CYC
) (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    // operator switch, high while pressed
    input  wire logic       switch_i,
    // indicators
    output logic            led_green_o,
    output logic            led_red_o,
    // settings
    output logic [7:0]      addr_o,
    output logic [3:0]      baud_code_o,
    output logic            cfg_active_o,
    output logic            applied_o
);
    localparam int TW = $clog2(TICK_CYC);

    // ---------------------------------------------------------
    // reset release and switch synchroniser
    // ---------------------------------------------------------
    logic [1:0] rst_q;
    logic       rst_n;
    logic       sw_q1, sw_q2, sw_q3, sw_level;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    wire sw_agree   = (sw_q2 == sw_q3);
    wire sw_press   = sw_agree && sw_q3 && !sw_level;
    wire sw_release = sw_agree && !sw_q3 && sw_level;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sw_q1    <= 1'b0;
            sw_q2    <= 1'b0;
            sw_q3    <= 1'b0;
            sw_level <= 1'b0;
        end else begin
            sw_q1    <= switch_i;
            sw_q2    <= sw_q1;
            sw_q3    <= sw_q2;
            sw_level <= sw_agree ? sw_q3 : sw_level;
        end
    end

    // ---------------------------------------------------------
    // slow time base, one pulse per 100 ms
    // ---------------------------------------------------------
    logic [TW-1:0] tick_cnt;
    logic          tick;
    wire           tick_end = (tick_cnt == TW'(TICK_CYC - 1));

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= tick_end ? '0 : tick_cnt + 1'b1;
            tick     <= tick_end;
        end
    end

    // ---------------------------------------------------------
    // state
    // ---------------------------------------------------------
    blabs_state_e state, next_state;
    blabs_phase_e phase, next_phase;
    logic [3:0]   slot, next_slot, sub, next_sub;
    logic [9:0]   wait_tk, next_wait_tk;
    logic [3:0]   hold_tk, gap_tk, next_hold_tk, next_gap_tk;
    logic [2:0]   presses, next_presses;
    logic [3:0]   tens, units, baud, next_tens, next_units, next_baud;
    logic [3:0]   tens_lat, units_lat, next_tens_lat, next_units_lat;
    logic         blink, next_blink, next_applied;
    blabs_led_s   mask, next_led;

    assign mask.green = (phase != BLABS_PH_UNITS);
    assign mask.red   = (phase != BLABS_PH_TENS);

    wire [3:0] cnt_max  = (phase == BLABS_PH_TENS)  ? BLABS_TENS_MAX  :
                          (phase == BLABS_PH_UNITS) ? BLABS_UNITS_MAX :
                                                      BLABS_BAUD_MAX;
    wire [3:0] show_val = (phase == BLABS_PH_TENS)  ? tens  :
                          (phase == BLABS_PH_UNITS) ? units : baud;
    wire slot_end = tick && (sub == BLABS_GAP_TK - 4'h1);
    wire gap_out  = tick && (gap_tk == BLABS_GAP_TK - 4'h1) && !sw_level;
    wire lit      = (slot != 4'h0) && (sub < BLABS_HALF_TK);

    always_comb begin
        next_state     = state;
        next_phase     = phase;
        next_slot      = slot;
        next_sub       = sub;
        next_wait_tk   = wait_tk;
        next_hold_tk   = hold_tk;
        next_gap_tk    = gap_tk;
        next_presses   = presses;
        next_tens      = tens;
        next_units     = units;
        next_baud      = baud;
        next_tens_lat  = tens_lat;
        next_units_lat = units_lat;
        next_blink     = 1'b0;
        next_applied   = 1'b0;
        next_led       = '0;
        case (state)
            BLABS_ST_RUN: begin
                next_phase = BLABS_PH_TENS;
                if (sw_press) begin
                    next_hold_tk = 4'h0;
                end else if (tick && sw_level && hold_tk != BLABS_GAP_TK) begin
                    next_hold_tk = hold_tk + 4'h1;
                end
                if (sw_release) begin
                    next_gap_tk  = 4'h0;
                    next_presses = (hold_tk >= BLABS_GAP_TK) ? 3'h0 :
                                   (presses == 3'h7) ? presses : presses + 3'h1;
                end else if (tick && !sw_level && gap_tk != BLABS_GAP_TK) begin
                    next_gap_tk = gap_tk + 4'h1;
                end
                // burst closes after 1 s quiet
                if (gap_out && presses == BLABS_CFG_PRESSES) begin
                    next_state   = BLABS_ST_WAIT;
                    next_wait_tk = 10'h0;
                end
                if (gap_out && presses == BLABS_SHOW_PRESSES) begin
                    next_state = BLABS_ST_SHOW;
                    next_slot  = 4'h0;
                    next_sub   = 4'h0;
                end
                if (gap_out) begin
                    next_presses = 3'h0;
                end
            end
            BLABS_ST_WAIT: begin
                next_blink = (tick && sub == BLABS_FAST_TK - 4'h1) ? !blink : blink;
                next_sub   = tick ? 4'h0 : sub;
                next_led.green = blink && mask.green;
                next_led.red   = blink && mask.red;
                if (sw_press) begin
                    next_state = BLABS_ST_COUNT;
                    next_slot  = 4'h0;
                    next_sub   = 4'h0;
                    next_led   = '0;
                    next_blink = 1'b0;
                end else if (tick && wait_tk == BLABS_TOUT_TK - 10'h1) begin
                    next_state = BLABS_ST_RUN;
                end else if (tick) begin
                    next_wait_tk = wait_tk + 10'h1;
                end
            end
            BLABS_ST_COUNT: begin
                // slot 0 dark, others half lit
                next_led.green = lit && mask.green;
                next_led.red   = lit && mask.red;
                if (tick) begin
                    next_sub = slot_end ? 4'h0 : sub + 4'h1;
                end
                if (slot_end) begin
                    next_slot = (slot == cnt_max) ? 4'h0 : slot + 4'h1;
                end
                if (sw_release) begin
                    next_state   = BLABS_ST_WAIT;
                    next_wait_tk = 10'h0;
                    next_sub     = 4'h0;
                    next_led     = '0;
                    case (phase)
                        BLABS_PH_TENS: begin
                            next_tens_lat = slot;
                            next_phase    = BLABS_PH_UNITS;
                        end
                        BLABS_PH_UNITS: begin
                            next_units_lat = slot;
                            next_phase     = BLABS_PH_BAUD;
                        end
                        default: begin
                            next_state   = BLABS_ST_RUN;
                            next_tens    = tens_lat;
                            next_units   = units_lat;
                            next_applied = 1'b1;
                            next_baud = (slot == 4'h0) ? baud : slot;
                        end
                    endcase
                end
            end
            BLABS_ST_SHOW: begin
                next_led.green = lit && mask.green;
                next_led.red   = lit && mask.red;
                if (tick) begin
                    next_sub = slot_end ? 4'h0 : sub + 4'h1;
                end
                if (slot_end && slot != show_val) begin
                    next_slot = slot + 4'h1;
                end else if (slot_end) begin
                    next_slot  = 4'h0;
                    next_phase = (phase == BLABS_PH_TENS)  ? BLABS_PH_UNITS :
                                 (phase == BLABS_PH_UNITS) ? BLABS_PH_BAUD  :
                                                             BLABS_PH_TENS;
                    next_state = (phase == BLABS_PH_BAUD) ? BLABS_ST_RUN : state;
                end
            end
            default: begin
                next_state = BLABS_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state     <= BLABS_ST_RUN;
            phase     <= BLABS_PH_TENS;
            slot      <= 4'h0;
            sub       <= 4'h0;
            wait_tk   <= 10'h0;
            hold_tk   <= 4'h0;
            gap_tk    <= 4'h0;
            presses   <= 3'h0;
            tens      <= BLABS_TENS_RST;
            units     <= BLABS_UNITS_RST;
            baud      <= BLABS_BAUD_RST;
            tens_lat  <= 4'h0;
            units_lat <= 4'h0;
            blink     <= 1'b0;
        end else begin
            state     <= next_state;
            phase     <= next_phase;
            slot      <= next_slot;
            sub       <= next_sub;
            wait_tk   <= next_wait_tk;
            hold_tk   <= next_hold_tk;
            gap_tk    <= next_gap_tk;
            presses   <= next_presses;
            tens      <= next_tens;
            units     <= next_units;
            baud      <= next_baud;
            tens_lat  <= next_tens_lat;
            units_lat <= next_units_lat;
            blink     <= next_blink;
        end
    end

    // ---------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------
    // decimal address from tens and units
    // operands widened first so a 4-bit product cannot overflow
    wire [7:0] next_addr = (8'(next_tens) * 8'(BLABS_TEN)) + 8'(next_units);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            led_green_o  <= 1'b0;
            led_red_o    <= 1'b0;
            addr_o       <= 8'(BLABS_TENS_RST * BLABS_TEN) + 8'(BLABS_UNITS_RST);
            baud_code_o  <= BLABS_BAUD_RST;
            cfg_active_o <= 1'b0;
            applied_o    <= 1'b0;
        end else begin
            led_green_o  <= next_led.green;
            led_red_o    <= next_led.red;
            addr_o       <= next_addr;
            baud_code_o  <= next_baud;
            cfg_active_o <= (next_state == BLABS_ST_WAIT) || (next_state == BLABS_ST_COUNT);
            applied_o    <= next_applied;
        end
    end

    // ---------------------------------------------------------
    // checks
    // ---------------------------------------------------------
    chk_enter_config: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_RUN && gap_out && presses == BLABS_CFG_PRESSES)
        |=> (state == BLABS_ST_WAIT && phase == BLABS_PH_TENS) ##1 cfg_active_o)
        else $error("five presses did not open configuration");

    chk_wait_timeout: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_WAIT && !sw_press && tick && wait_tk == BLABS_TOUT_TK - 10'h1)
        |=> state == BLABS_ST_RUN ##1 !cfg_active_o)
        else $error("wait window did not expire");

    chk_baud_blink: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_WAIT && phase == BLABS_PH_BAUD)
        |=> led_green_o == led_red_o)
        else $error("baud wait blink not on both LEDs");

    chk_press_dark: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_WAIT && sw_press)
        |=> (state == BLABS_ST_COUNT) ##1 (!led_green_o && !led_red_o))
        else $error("press did not blank and start counting");

    chk_zero_dark: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_COUNT && slot == 4'h0)
        |=> !led_green_o && !led_red_o)
        else $error("LED lit in zero slot");

    chk_tens_wrap: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_COUNT && phase == BLABS_PH_TENS && !sw_release
         && slot_end && slot == 4'hC) |=> slot == 4'h0)
        else $error("tens did not wrap after 12");

    chk_units_max: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_COUNT && phase == BLABS_PH_UNITS) |-> slot <= 4'h9)
        else $error("units count above 9");

    chk_baud_wrap: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_COUNT && phase == BLABS_PH_BAUD && !sw_release
         && slot_end && slot == 4'h5) |=> slot == 4'h0)
        else $error("baud code did not wrap after 5");

    chk_baud_keep: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_COUNT && phase == BLABS_PH_BAUD && sw_release && slot == 4'h0)
        |=> applied_o && $stable(baud_code_o))
        else $error("zero baud code changed the rate");

    chk_apply_addr: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_COUNT && phase == BLABS_PH_BAUD && sw_release)
        |=> applied_o && state == BLABS_ST_RUN
            && addr_o == (8'(tens_lat) * 8'(BLABS_TEN)) + 8'(units_lat))
        else $error("settings not applied on baud release");

    chk_phase_order: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_COUNT && phase == BLABS_PH_TENS && sw_release)
        |=> state == BLABS_ST_WAIT && phase == BLABS_PH_UNITS && tens_lat == $past(slot))
        else $error("tens release did not move to units");

    chk_show_keeps: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        (state == BLABS_ST_SHOW) |=> $stable(addr_o) && $stable(baud_code_o))
        else $error("read-out changed settings");

endmodule : blabs_top

// ===== verif/blabs_operator.sv
// operator model: a person pressing the push switch
`timescale 1ns/10ps

module blabs_operator #(
    parameter int TICK_CYC = 4
) (
    // clock
    input  wire logic sys_clk_i,
    // switch, high while pressed
    output logic      switch_o
);
    initial switch_o = 1'b0;

    task automatic wait_ticks(input int n);
        repeat (n * TICK_CYC) @(posedge sys_clk_i);
    endtask : wait_ticks

    task automatic down();
        @(posedge sys_clk_i);
        switch_o <= 1'b1;
    endtask : down

    task automatic up();
        @(posedge sys_clk_i);
        switch_o <= 1'b0;
    endtask : up

    // short presses well inside the one second gap
    task automatic burst(input int n);
        repeat (n) begin
            down();
            wait_ticks(2);
            up();
            wait_ticks(3);
        end
    endtask : burst

    // release mid-slot
    // mid-slot release keeps five ticks, half a slot, of margin against time-base jitter
    task automatic enter_value(input int k);
        down();
        wait_ticks(10 * k + 5);
        up();
    endtask : enter_value
endmodule : blabs_operator

// ===== verif/blabs_tb.sv
// self-checking bench of the address and baud sequencer
`timescale 1ns/10ps

module testbench
    import blabs_pkg::*;
;
    localparam int TK = 4;

    logic       sys_clk_i;
    logic       resetn_i;
    logic       switch_i;
    logic       led_green_o;
    logic       led_red_o;
    logic [7:0] addr_o;
    logic [3:0] baud_code_o;
    logic       cfg_active_o;
    logic       applied_o;
    int         err_total   = 0;
    int         comparisons = 0;
    int         n_applied   = 0;
    int         n_cfg       = 0;

    blabs_top #(.TICK_CYC(TK)) uut (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .switch_i    (switch_i),
        .led_green_o (led_green_o),
        .led_red_o   (led_red_o),
        .addr_o      (addr_o),
        .baud_code_o (baud_code_o),
        .cfg_active_o(cfg_active_o),
        .applied_o   (applied_o)
    );

    blabs_operator #(.TICK_CYC(TK)) op (
        .sys_clk_i(sys_clk_i),
        .switch_o (switch_i)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (applied_o === 1'b1) n_applied <= n_applied + 1;
        if (cfg_active_o === 1'b1) n_cfg <= n_cfg + 1;
    end

    // --------------------------------------
    // shared tasks
    // --------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // bounded wait, n returns the cycles spent
    task automatic wait_cfg(input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (cfg_active_o !== v && n <= lim);
        if (cfg_active_o !== v) begin
            check("cfg_active_wait", cfg_active_o, v);
            final_report();
        end
    endtask : wait_cfg

    task automatic count_flash(input int ncyc, output int g, output int r);
        logic pg;
        logic pr;
        g = 0;
        r = 0;
        // first sample off the launching edge, so the window spans whole cycles
        @(negedge sys_clk_i);
        pg = led_green_o;
        pr = led_red_o;
        repeat (ncyc) begin
            @(negedge sys_clk_i);
            if (led_green_o === 1'b1 && pg !== 1'b1) g++;
            if (led_red_o === 1'b1 && pr !== 1'b1) r++;
            pg = led_green_o;
            pr = led_red_o;
        end
    endtask : count_flash

    // a 0.1/0.1 s blink gives exactly 5 rises in 10 ticks
    task automatic blink_check(input int g_exp, input int r_exp);
        int g;
        int r;
        op.wait_ticks(2);
        count_flash(10 * TK, g, r);
        check("blink_green", g, g_exp);
        check("blink_red", r, r_exp);
    endtask : blink_check

    task automatic enter_cfg();
        int n;
        op.burst(5);
        wait_cfg(1'b1, 14 * TK, n);
        check("burst_quiet", n >= 5 * TK, 1);
    endtask : enter_cfg

    task automatic phase(input int k, input int g, input int r);
        blink_check(g * 5, r * 5);
        op.enter_value(k);
    endtask : phase

    task automatic finish_cfg(input int a, input int b);
        int n;
        int n0;
        n0 = n_applied;
        wait_cfg(1'b0, 20, n);
        repeat (4) @(negedge sys_clk_i);
        check("applied_pulses", n_applied - n0, 1);
        check("addr_o", addr_o, a);
        check("baud_code_o", baud_code_o, b);
    endtask : finish_cfg

    task automatic run_cfg(input int t, input int u, input int b, input int a, input int bd);
        enter_cfg();
        phase(t, 1, 0);
        phase(u, 0, 1);
        phase(b, 1, 1);
        finish_cfg(a, bd);
    endtask : run_cfg

    // --------------------------------------
    // scenarios
    // --------------------------------------
    task automatic scen_reset();
        repeat (10) @(negedge sys_clk_i);
        check("addr_rst", addr_o, 8'h01);
        check("baud_rst", baud_code_o, 4'h2);
        check("leds_rst", {led_green_o, led_red_o}, 2'h0);
        check("cfg_rst", cfg_active_o, 1'b0);
    endtask : scen_reset

    // tens counted by hand, sampled 2.5 ticks into each half slot
    task automatic scen_basic();
        enter_cfg();
        blink_check(5, 0);
        op.down();
        for (int i = 0; i < 5; i++) begin
            repeat (i == 0 ? 10 : 20) @(negedge sys_clk_i);
            check("count_green", led_green_o, i >= 2 && i % 2 == 0);
            check("count_red", led_red_o, 1'b0);
        end
        op.wait_ticks(2);
        op.up();
        phase(3, 0, 1);
        phase(3, 1, 1);
        finish_cfg(23, 3);
    endtask : scen_basic

    task automatic scen_readout(input int t, input int u, input int b);
        int g;
        int r;
        int c0;
        c0 = n_cfg;
        op.burst(4);
        op.wait_ticks(15);
        check("four_presses", n_cfg - c0, 0);
        op.burst(3);
        count_flash((t + u + b + 5) * 10 * TK, g, r);
        check("show_green", g, t + b);
        check("show_red", r, u + b);
        check("show_cfg", n_cfg - c0, 0);
        check("show_addr", addr_o, t * 10 + u);
        check("show_baud", baud_code_o, b);
    endtask : scen_readout

    // reset in the middle of a configuration restores the defaults
    task automatic scen_reset_mid();
        enter_cfg();
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        scen_reset();
    endtask : scen_reset_mid

    task automatic scen_timeout();
        int n;
        int n0;
        n0 = n_applied;
        enter_cfg();
        wait_cfg(1'b0, 610 * TK, n);
        check("timeout_len", n > 595 * TK && n < 605 * TK, 1);
        check("timeout_apply", n_applied - n0, 0);
        check("timeout_addr", addr_o, 8'h17);
        check("timeout_baud", baud_code_o, 4'h3);
    endtask : scen_timeout

    initial begin
        resetn_i = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        scen_reset();
        scen_basic();
        scen_readout(2, 3, 3);
        scen_timeout();
        // tens wrap, quick zero units, baud zero keeps rate
        run_cfg(14, 0, 0, 10, 3);
        // units and baud wrap
        run_cfg(0, 12, 7, 2, 1);
        run_cfg(9, 9, 4, 99, 4);
        scen_reset_mid();
        // no range check on the address
        run_cfg(12, 5, 5, 125, 5);
        run_cfg(0, 1, 2, 1, 2);
        final_report();
    end
endmodule : testbench
